// *** rtl/sup_packer.sv ***
// Purpose: Packs serial bytes into datagrams released toward a UDP transmit path
// Assumes: Serial bytes and ms tick synchronous to i_clk
// Notes:   Bytes arriving while a release drains are refused via o_rx_ready
// What this block does
// - Length zero means no length limit
// - Release when byte count equals packet length
// - Enabled first delimiter match releases buffer
// - Enabled second delimiter acts like first, but only while the first delimiter is also enabled
// - Full buffer releases automatically
// - Plus-one/plus-two wait for trailing bytes
// - Strip option drops the delimiter byte
// - Default option releases with delimiter kept
// - Force-transmit zero disables timeout release
// - Nonzero force-transmit releases after that many ms
// - Four destination entries, port default 4001
// - Local listen port, default 4001
`timescale 1ns/1ps
`default_nettype none
module sup_packer
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst_b,
   input  wire logic        i_ms_tick,
   // Configuration
   input  wire logic [10:0] i_pkt_len,
   input  wire logic        i_dlm1_en,
   input  wire logic [7:0]  i_dlm1,
   input  wire logic        i_dlm2_en,
   input  wire logic [7:0]  i_dlm2,
   input  wire logic [1:0]  i_dproc,
   input  wire logic [15:0] i_force_ms,
   input  wire logic        i_cfg_load,
   input  wire logic [127:0] i_dst_begin,
   input  wire logic [127:0] i_dst_end,
   input  wire logic [63:0] i_dst_port,
   input  wire logic [3:0]  i_dst_en,
   input  wire logic [15:0] i_listen_port,
   // Serial side
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_data,
   output logic             o_rx_ready,
   // Transmit side
   output logic             o_tx_valid,
   output logic [7:0]       o_tx_data,
   output logic             o_tx_last,
   input  wire logic        i_tx_ready,
   // Destination and listen settings
   output logic [127:0]     o_dst_begin,
   output logic [127:0]     o_dst_end,
   output logic [63:0]      o_dst_port,
   output logic [3:0]       o_dst_en,
   output logic [15:0]      o_listen_port,
   // Status
   output logic [10:0]      o_fill
);
   sup_mem_if mif ();

   sup_byte_mem u_mem
   (
      .i_clk  (i_clk),
      .mem_if (mif)
   );

   function automatic logic dlm_hit(input logic [7:0] b, input logic e1, input logic [7:0] d1,
                                    input logic e2, input logic [7:0] d2);
      dlm_hit = e1 && ((b == d1) || (e2 && (b == d2)));
   endfunction

   sup_pkg::sup_state_t st_ff, nxt_st;
   logic [10:0] cnt_ff, nxt_cnt;
   logic [10:0] rel_ff, nxt_rel;
   logic [10:0] rd_ff, nxt_rd;
   logic [1:0]  tail_ff, nxt_tail;
   logic        tail_act_ff, nxt_tail_act;
   logic [15:0] ms_ff, nxt_ms;
   logic        pend_ff, nxt_pend;
   logic        txv_ff, nxt_txv;
   logic        txl_ff, nxt_txl;
   logic        rdy_ff, nxt_rdy;
   logic        lastq_ff, nxt_lastq;
   logic        take;
   logic        hit;
   logic        wr_en;
   logic        rel_now;
   logic [10:0] rel_cnt;

   assign take = i_rx_valid && rdy_ff;
   assign hit  = dlm_hit(i_rx_data, i_dlm1_en, i_dlm1, i_dlm2_en, i_dlm2);

   always_comb
   begin
      nxt_st       = st_ff;
      nxt_cnt      = cnt_ff;
      nxt_rel      = rel_ff;
      nxt_rd       = rd_ff;
      nxt_tail     = tail_ff;
      nxt_tail_act = tail_act_ff;
      nxt_ms       = ms_ff;
      nxt_pend     = pend_ff;
      nxt_txv      = txv_ff;
      nxt_txl      = txl_ff;
      nxt_lastq    = lastq_ff;
      wr_en        = 1'b0;
      rel_now      = 1'b0;
      rel_cnt      = cnt_ff;
      mif.rd_en    = 1'b0;
      mif.rd_addr  = rd_ff[9:0];
      case (st_ff)
         sup_pkg::SUP_ST_FILL:
         begin
            if (i_ms_tick && (cnt_ff != 11'h000) && (i_force_ms != sup_pkg::FORCE_MS_RST))
            begin
               nxt_ms = ms_ff + 16'h0001;
            end
            if (take)
            begin
               wr_en   = !(hit && !tail_act_ff && (i_dproc == sup_pkg::SUP_DP_STRIP));
               rel_cnt = wr_en ? cnt_ff + 11'h001 : cnt_ff;
               nxt_cnt = rel_cnt;
               if (tail_act_ff)
               begin
                  nxt_tail = tail_ff - 2'h1;
                  rel_now  = (tail_ff == 2'h1);
               end
               else if (hit)
               begin
                  case (i_dproc)
                     sup_pkg::SUP_DP_PLUS1:
                     begin
                        nxt_tail_act = 1'b1;
                        nxt_tail     = 2'h1;
                     end
                     sup_pkg::SUP_DP_PLUS2:
                     begin
                        nxt_tail_act = 1'b1;
                        nxt_tail     = 2'h2;
                     end
                     default: rel_now = 1'b1;
                  endcase
               end
               if ((i_pkt_len != sup_pkg::PKT_LEN_RST) && (rel_cnt == i_pkt_len))
               begin
                  rel_now = 1'b1;
               end
               if (rel_cnt == sup_pkg::BUF_FULL_CNT)
               begin
                  rel_now = 1'b1;
               end
            end
            else if ((i_force_ms != sup_pkg::FORCE_MS_RST) && (cnt_ff != 11'h000)
                     && (ms_ff >= i_force_ms))
            begin
               rel_now = 1'b1;
            end
            if (rel_now && (rel_cnt != 11'h000))
            begin
               nxt_st       = sup_pkg::SUP_ST_DRAIN;
               nxt_rel      = rel_cnt;
               nxt_rd       = 11'h000;
               nxt_tail_act = 1'b0;
               nxt_ms       = 16'h0000;
               nxt_pend     = 1'b0;
            end
            else if (rel_now)
            begin
               nxt_tail_act = 1'b0;
            end
         end
         sup_pkg::SUP_ST_DRAIN:
         begin
            // Prefetch one byte; output register holds until accepted
            if (!pend_ff && (!txv_ff || i_tx_ready) && (rd_ff != rel_ff))
            begin
               mif.rd_en = 1'b1;
               nxt_rd    = rd_ff + 11'h001;
               nxt_pend  = 1'b1;
               nxt_lastq = (rd_ff + 11'h001 == rel_ff);
            end
            if (txv_ff && i_tx_ready)
            begin
               nxt_txv = 1'b0;
               nxt_txl = 1'b0;
               if (txl_ff)
               begin
                  nxt_st  = sup_pkg::SUP_ST_FILL;
                  nxt_cnt = 11'h000;
               end
            end
            if (pend_ff)
            begin
               nxt_pend = 1'b0;
               nxt_txv  = 1'b1;
               nxt_txl  = lastq_ff;
            end
         end
         default: nxt_st = sup_pkg::SUP_ST_FILL;
      endcase
      nxt_rdy = (nxt_st == sup_pkg::SUP_ST_FILL);
   end

   always_comb
   begin
      mif.wr_en   = wr_en;
      mif.wr_addr = cnt_ff[9:0];
      mif.wr_data = i_rx_data;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         st_ff       <= sup_pkg::SUP_ST_FILL;
         cnt_ff      <= 11'h000;
         rel_ff      <= 11'h000;
         rd_ff       <= 11'h000;
         tail_ff     <= 2'h0;
         tail_act_ff <= 1'b0;
         ms_ff       <= 16'h0000;
         pend_ff     <= 1'b0;
         txv_ff      <= 1'b0;
         txl_ff      <= 1'b0;
         rdy_ff      <= 1'b0;
         lastq_ff    <= 1'b0;
      end
      else
      begin
         st_ff       <= nxt_st;
         cnt_ff      <= nxt_cnt;
         rel_ff      <= nxt_rel;
         rd_ff       <= nxt_rd;
         tail_ff     <= nxt_tail;
         tail_act_ff <= nxt_tail_act;
         ms_ff       <= nxt_ms;
         pend_ff     <= nxt_pend;
         txv_ff      <= nxt_txv;
         txl_ff      <= nxt_txl;
         rdy_ff      <= nxt_rdy;
         lastq_ff    <= nxt_lastq;
      end
   end

   // Destination table latched on load so the transmit path sees a stable set
   logic [127:0] db_ff, de_ff;
   logic [63:0]  dp_ff;
   logic [3:0]   den_ff;
   logic [15:0]  lp_ff;
   logic [127:0] nxt_db, nxt_de;
   logic [63:0]  nxt_dp;
   logic [3:0]   nxt_den;
   logic [15:0]  nxt_lp;

   always_comb
   begin
      nxt_db  = i_cfg_load ? i_dst_begin : db_ff;
      nxt_de  = i_cfg_load ? i_dst_end : de_ff;
      nxt_dp  = i_cfg_load ? i_dst_port : dp_ff;
      nxt_den = i_cfg_load ? (i_dst_en | 4'h1) : den_ff;
      nxt_lp  = (i_cfg_load && (i_listen_port != 16'h0000)) ? i_listen_port : lp_ff;
   end

   always_ff @(posedge i_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         db_ff  <= {sup_pkg::DEST_NUM{sup_pkg::ADDR_RST}};
         de_ff  <= {sup_pkg::DEST_NUM{sup_pkg::ADDR_RST}};
         dp_ff  <= {sup_pkg::DEST_NUM{sup_pkg::PORT_RST}};
         den_ff <= 4'h1;
         lp_ff  <= sup_pkg::PORT_RST;
      end
      else
      begin
         db_ff  <= nxt_db;
         de_ff  <= nxt_de;
         dp_ff  <= nxt_dp;
         den_ff <= nxt_den;
         lp_ff  <= nxt_lp;
      end
   end

   assign o_rx_ready    = rdy_ff;
   assign o_tx_valid    = txv_ff;
   assign o_tx_data     = mif.rd_data;
   assign o_tx_last     = txl_ff;
   assign o_dst_begin   = db_ff;
   assign o_dst_end     = de_ff;
   assign o_dst_port    = dp_ff;
   assign o_dst_en      = den_ff;
   assign o_listen_port = lp_ff;
   assign o_fill        = cnt_ff;
endmodule
`default_nettype wire

// *** rtl/sup_pkg.sv ***
// Purpose: Shared constants and types for the serial-to-datagram packer
// Assumes: One clock at 100 MHz, one-millisecond tick supplied from outside
// Notes:   Widths fixed; buffer holds 1024 bytes
package sup_pkg;
   localparam int          BUF_DEPTH     = 1024;
   localparam int          PTR_W         = 10;
   localparam int          CNT_W         = 11;
   localparam logic [10:0] BUF_FULL_CNT  = 11'h400;
   localparam logic [10:0] PKT_LEN_MAX   = 11'h400;
   localparam logic [10:0] PKT_LEN_RST   = 11'h000;
   localparam logic [15:0] FORCE_MS_RST  = 16'h0000;
   localparam logic [15:0] PORT_RST      = 16'h0fa1;
   localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
   localparam int          DEST_NUM      = 4;

   // Delimiter handling options
   typedef enum logic [1:0]
   {
      SUP_DP_NONE  = 2'h0,
      SUP_DP_PLUS1 = 2'h1,
      SUP_DP_PLUS2 = 2'h2,
      SUP_DP_STRIP = 2'h3
   } sup_dproc_t;

   // Gray codes along fill -> drain -> last
   typedef enum logic [1:0]
   {
      SUP_ST_FILL  = 2'h0,
      SUP_ST_DRAIN = 2'h1,
      SUP_ST_LAST  = 2'h3
   } sup_state_t;
endpackage

// *** rtl/sup_mem_if.sv ***
// Purpose: Carrier between the packer and its byte memory
// Assumes: Single clock
// Notes:   Read data valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
interface sup_mem_if;
   logic       wr_en;
   logic [9:0] wr_addr;
   logic [7:0] wr_data;
   logic       rd_en;
   logic [9:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
   modport mem  (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** rtl/sup_byte_mem.sv ***
// Purpose: 1024 x 8 byte store for the packer
// Assumes: Single clock
// Notes:   Read data comes from a register
`timescale 1ns/1ps
`default_nettype none
module sup_byte_mem
(
   // Clock
   input  wire logic i_clk,
   // Access
   sup_mem_if.mem    mem_if
);
   logic [7:0] mem_q [0:sup_pkg::BUF_DEPTH-1];
   logic [7:0] rd_ff;

   always_ff @(posedge i_clk)
   begin
      if (mem_if.wr_en)
      begin
         mem_q[mem_if.wr_addr] <= mem_if.wr_data;
      end
      if (mem_if.rd_en)
      begin
         rd_ff <= mem_q[mem_if.rd_addr];
      end
   end

   assign mem_if.rd_data = rd_ff;
endmodule
`default_nettype wire

// *** verif/sup_packer_assertions.sv ***
// Purpose: Port checks for sup_packer
// Assumes: One clock, reset async active low
// Notes:   Bound to every sup_packer at the foot
`timescale 1ns/1ps
`default_nettype none
module sup_packer_chk
(
   // Clock and reset
   input wire logic        i_clk,
   input wire logic        i_rst_b,
   // Configuration
   input wire logic [10:0] i_pkt_len,
   input wire logic        i_dlm1_en,
   input wire logic [7:0]  i_dlm1,
   input wire logic [1:0]  i_dproc,
   input wire logic [15:0] i_force_ms,
   input wire logic        i_cfg_load,
   input wire logic [15:0] i_listen_port,
   input wire logic [15:0] o_listen_port,
   // Streams
   input wire logic        i_rx_valid,
   input wire logic [7:0]  i_rx_data,
   input wire logic        o_rx_ready,
   input wire logic        o_tx_valid,
   input wire logic [7:0]  o_tx_data,
   input wire logic        o_tx_last,
   input wire logic        i_tx_ready,
   input wire logic [10:0] o_fill
);
   logic acc;
   assign acc = i_rx_valid && o_rx_ready;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   property p_hold; o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable({o_tx_data, o_tx_last});
   endproperty
   a_hold: assert property (p_hold) else $error("tx byte moved");
   // Strip mode may drop the byte, so left out
   property p_fill; acc && i_dproc != 2'h3 |=> o_fill == $past(o_fill) + 11'h001; endproperty
   a_fill: assert property (p_fill) else $error("fill not counted");
   property p_len; acc && i_pkt_len != 11'h000 && o_fill + 11'h001 == i_pkt_len
      && i_dproc != 2'h3 |-> ##[2:5] o_tx_valid; endproperty
   a_len: assert property (p_len) else $error("length release missing");
   property p_full; acc && o_fill == 11'h3ff |-> ##[2:5] o_tx_valid; endproperty
   a_full: assert property (p_full) else $error("full release missing");
   property p_dlm; acc && i_dlm1_en && i_rx_data == i_dlm1 && i_dproc == 2'h0
      |-> ##[2:5] o_tx_valid; endproperty
   a_dlm: assert property (p_dlm) else $error("delimiter release missing");
   property p_done; o_tx_valid && o_tx_last && i_tx_ready |=> ##[0:1] o_fill == 11'h000
      && o_rx_ready; endproperty
   a_done: assert property (p_done) else $error("buffer not emptied");
   property p_cfg; i_cfg_load && i_listen_port != 16'h0000 |=> o_listen_port ==
      $past(i_listen_port); endproperty
   a_cfg: assert property (p_cfg) else $error("listen port not loaded");
   property p_idle; i_force_ms == 16'h0000 && o_rx_ready && !i_rx_valid && !$past(i_rx_valid)
      |=> o_rx_ready; endproperty
   a_idle: assert property (p_idle) else $error("release with timeout off");
endmodule
bind sup_packer sup_packer_chk u_chk
(
   .i_clk         (i_clk),
   .i_rst_b       (i_rst_b),
   .i_pkt_len     (i_pkt_len),
   .i_dlm1_en     (i_dlm1_en),
   .i_dlm1        (i_dlm1),
   .i_dproc       (i_dproc),
   .i_force_ms    (i_force_ms),
   .i_cfg_load    (i_cfg_load),
   .i_listen_port (i_listen_port),
   .o_listen_port (o_listen_port),
   .i_rx_valid    (i_rx_valid),
   .i_rx_data     (i_rx_data),
   .o_rx_ready    (o_rx_ready),
   .o_tx_valid    (o_tx_valid),
   .o_tx_data     (o_tx_data),
   .o_tx_last     (o_tx_last),
   .i_tx_ready    (i_tx_ready),
   .o_fill        (o_fill)
);
`default_nettype wire

// *** verif/sup_tx_sink.sv ***
// Purpose: Transmit path stand-in for the packer
// Assumes: Byte taken on valid and ready
// Notes:   Slow mode stalls every other cycle
`timescale 1ns/1ps
`default_nettype none
module sup_tx_sink
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst_b,
   // Control and handshake
   input  wire logic i_slow,
   output logic      o_ready
);
   // Stalls exercise the hold of a waiting byte
   always_ff @(posedge i_clk or negedge i_rst_b)
      if (!i_rst_b)
         o_ready <= 1'b0;
      else
         o_ready <= i_slow ? ~o_ready : 1'b1;
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for sup_packer
// Assumes: Inputs change at the falling edge
// Notes:   Full-buffer case dominates run time
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic         i_clk = 1'b0, i_rst_b = 1'b0, i_ms_tick = 1'b0, i_cfg_load = 1'b0;
   logic         i_dlm1_en = 1'b0, i_dlm2_en = 1'b0, i_rx_valid = 1'b0, i_slow = 1'b0;
   logic [10:0]  i_pkt_len = '0;
   logic [7:0]   i_dlm1 = '0, i_dlm2 = '0, i_rx_data = '0;
   logic [1:0]   i_dproc = '0;
   logic [15:0]  i_force_ms = '0, i_listen_port = '0;
   logic [127:0] i_dst_begin = '0, i_dst_end = '0;
   logic [63:0]  i_dst_port = '0;
   logic [3:0]   i_dst_en = '0;
   logic         o_rx_ready, o_tx_valid, o_tx_last, i_tx_ready;
   logic [7:0]   o_tx_data;
   logic [127:0] o_dst_begin, o_dst_end;
   logic [63:0]  o_dst_port;
   logic [3:0]   o_dst_en;
   logic [15:0]  o_listen_port;
   logic [10:0]  o_fill;
   logic [7:0]   got[$];
   logic [7:0]   e[$];
   int           err_count = 0, n_compared = 0, pkts = 0, cyc = 0;
   always #5 i_clk = ~i_clk;
   sup_packer uut
   (
      .i_clk         (i_clk),
      .i_rst_b       (i_rst_b),
      .i_ms_tick     (i_ms_tick),
      .i_pkt_len     (i_pkt_len),
      .i_dlm1_en     (i_dlm1_en),
      .i_dlm1        (i_dlm1),
      .i_dlm2_en     (i_dlm2_en),
      .i_dlm2        (i_dlm2),
      .i_dproc       (i_dproc),
      .i_force_ms    (i_force_ms),
      .i_cfg_load    (i_cfg_load),
      .i_dst_begin   (i_dst_begin),
      .i_dst_end     (i_dst_end),
      .i_dst_port    (i_dst_port),
      .i_dst_en      (i_dst_en),
      .i_listen_port (i_listen_port),
      .i_rx_valid    (i_rx_valid),
      .i_rx_data     (i_rx_data),
      .o_rx_ready    (o_rx_ready),
      .o_tx_valid    (o_tx_valid),
      .o_tx_data     (o_tx_data),
      .o_tx_last     (o_tx_last),
      .i_tx_ready    (i_tx_ready),
      .o_dst_begin   (o_dst_begin),
      .o_dst_end     (o_dst_end),
      .o_dst_port    (o_dst_port),
      .o_dst_en      (o_dst_en),
      .o_listen_port (o_listen_port),
      .o_fill        (o_fill)
   );
   sup_tx_sink u_sink (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_slow(i_slow), .o_ready(i_tx_ready));
   // Collector and hang guard; sampled off the edge so the handshake has settled
   always @(negedge i_clk)
   begin
      cyc++;
      if (o_tx_valid && i_tx_ready)
      begin
         got.push_back(o_tx_data);
         pkts += o_tx_last;
      end
      if (cyc == 20000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [127:0] x, input logic [127:0] g);
      n_compared++;
      if (g !== x)
      begin
         err_count++;
         $display("CHECK FAILED %s exp %0h got %0h", n, x, g);
      end
   endtask
   task automatic send(input logic [7:0] b);
      @(negedge i_clk);
      i_rx_valid = 1'b1;
      i_rx_data = b;
      while (!o_rx_ready)
         @(negedge i_clk);
      @(negedge i_clk);
      i_rx_valid = 1'b0;
   endtask
   task automatic tick(input int n);
      repeat (n)
      begin
         @(negedge i_clk);
         i_ms_tick = 1'b1;
         @(negedge i_clk);
         i_ms_tick = 1'b0;
      end
   endtask
   // Waits for one datagram and compares it with e
   task automatic fin;
      wait (pkts == 1);
      repeat (4) @(negedge i_clk);
      chk("pkt_size", e.size(), got.size());
      foreach (e[i])
         chk("pkt_byte", e[i], got[i]);
      chk("pkt_count", 1, pkts);
      got.delete();
      e.delete();
      pkts = 0;
   endtask
   task automatic load(input logic [15:0] lp);
      i_listen_port = lp;
      i_cfg_load = 1'b1;
      @(negedge i_clk);
      i_cfg_load = 1'b0;
      repeat (2) @(negedge i_clk);
   endtask
   task automatic t_cfg;
      chk("listen", 16'h0fa1, o_listen_port);
      chk("dst_port", 64'h0fa1_0fa1_0fa1_0fa1, o_dst_port);
      chk("dst_en", 4'h1, o_dst_en);
      chk("dst_begin", 128'h0, o_dst_begin);
      i_dst_begin = {4{32'h0a00_0001}};
      i_dst_end = {4{32'h0a00_0009}};
      i_dst_port = 64'h1111_2222_3333_4444;
      i_dst_en = 4'h6;
      load(16'h1234);
      load(16'h0000);
      chk("dst_begin", {4{32'h0a00_0001}}, o_dst_begin);
      chk("dst_end", {4{32'h0a00_0009}}, o_dst_end);
      chk("dst_port", 64'h1111_2222_3333_4444, o_dst_port);
      chk("dst_en", 4'h7, o_dst_en);
      chk("listen", 16'h1234, o_listen_port);
   endtask
   task automatic t_len;
      i_pkt_len = 11'h004;
      for (int k = 1; k <= 4; k++)
      begin
         e.push_back(8'(k));
         send(8'(k));
      end
      fin();
      i_pkt_len = 11'h000;
   endtask
   task automatic t_dlm;
      logic [7:0] s[$];
      int         n;
      s = '{8'h11, 8'h22, 8'h0d, 8'h33, 8'h44};
      i_dlm1_en = 1'b1;
      i_dlm1 = 8'h0d;
      i_slow = 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         i_dproc = 2'(m);
         n = (m == 3) ? 3 : 3 + m;
         for (int k = 0; k < n; k++)
            send(s[k]);
         e = s[0:((m == 3) ? 1 : n - 1)];
         fin();
      end
      i_dproc = 2'h0;
      i_dlm2_en = 1'b1;
      i_dlm2 = 8'h7e;
      send(8'h55);
      send(8'h7e);
      e = '{8'h55, 8'h7e};
      fin();
      i_dlm1_en = 1'b0;
      i_dlm2_en = 1'b0;
   endtask
   task automatic t_to;
      send(8'hb6);
      chk("fill", 11'h001, o_fill);
      tick(12);
      chk("pkt_count", 0, pkts);
      // Interval only counts while enabled, so ticks start again from zero
      i_force_ms = 16'h000b;
      tick(10);
      chk("pkt_count", 0, pkts);
      tick(1);
      e = '{8'hb6};
      fin();
      send(8'ha5);
      tick(10);
      chk("pkt_count", 0, pkts);
      tick(1);
      e = '{8'ha5};
      fin();
      i_force_ms = 16'h0000;
   endtask
   task automatic t_full;
      for (int k = 0; k < 1024; k++)
      begin
         e.push_back(k[7:0]);
         send(k[7:0]);
      end
      fin();
   endtask
   initial
   begin
      repeat (2) @(negedge i_clk);
      i_rst_b = 1'b1;
      repeat (2) @(negedge i_clk);
      t_cfg();
      t_len();
      t_dlm();
      t_to();
      t_full();
      tally_and_finish();
   end
endmodule
`default_nettype wire
